// ==== core/pif_pkg.sv ====
/*
  Shared constants and types of the peripheral request flag block:
  register offsets, flag bit positions, reset values, the capture/compare
  mode encoding and the state record of the top module.
  Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
*/
package pif_pkg;

  // number of implemented flags, bits 5..0
  localparam int unsigned FLAG_W = 6;

  // register byte offsets
  localparam logic [3:0] OFF_FLAGS = 4'h0;
  localparam logic [3:0] OFF_STAT  = 4'h4;
  localparam logic [3:0] OFF_MASK  = 4'h8;
  localparam logic [3:0] OFF_MODE  = 4'hC;

  // flag bit positions
  localparam int unsigned BIT_USB   = 5;
  localparam int unsigned BIT_NVM   = 4;
  localparam int unsigned BIT_BCOL  = 3;
  localparam int unsigned BIT_VDET  = 2;
  localparam int unsigned BIT_TIMER_THREE  = 1;
  localparam int unsigned BIT_CCP2  = 0;

  // mode field position and width
  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned MODE_W    = 2;

  // reset values
  localparam logic [5:0]  RST_FLAGS = 6'h00;
  localparam logic [5:0]  RST_STAT  = 6'h00;
  localparam logic [5:0]  RST_MASK  = 6'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // capture/compare unit two operating mode
  typedef enum logic [1:0] {
    PIF_MODE_CAPTURE = 2'b00,
    PIF_MODE_COMPARE = 2'b01,
    PIF_MODE_PWM     = 2'b10,
    PIF_MODE_OFF     = 2'b11
  } pif_ccp_mode_t;

  localparam pif_ccp_mode_t RST_MODE = PIF_MODE_CAPTURE;

  // state record of the top module
  typedef struct packed {
    logic          waitreq;
    logic [31:0]   rdata;
    logic [5:0]    stat;
    logic [5:0]    mask;
    pif_ccp_mode_t mode;
    logic          irq;
  } pif_state_t;

  // state record of one flag cell
  typedef struct packed {
    logic flag;
  } pif_cell_t;

endpackage : pif_pkg

// ==== core/pif_flag_cell.sv ====
/*
  One request flag bit: set by a peripheral event pulse, written by
  software, with the event taking precedence over a same-cycle write.
  Assumes the event pulse and write strobe are on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pif_flag_cell (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // event side
  input  wire logic set_i,
  // software side
  input  wire logic wr_en_i,
  input  wire logic wr_val_i,
  // flag
  output logic      flag_o
);

  pif_pkg::pif_cell_t st_r;
  pif_pkg::pif_cell_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (wr_en_i)
    begin
      st_nxt.flag = wr_val_i;
    end
    // a same-cycle event overrides the software write
    if (set_i)
    begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_r.flag <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;

endmodule : pif_flag_cell
`default_nettype wire

// ==== core/pif_flags.sv ====
/*
  Peripheral request flag register two, low six bits, with an Avalon-MM
  slave, a sticky write-one-to-clear interrupt status, a mask and one
  level interrupt output.
  Assumes all event inputs are single-cycle pulses on clk_i.
*/
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pif_flags (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // peripheral event pulses
  input  wire logic        usb_req_i,
  input  wire logic        nvm_write_done_i,
  input  wire logic        bus_collision_i,
  input  wire logic        voltage_trip_i,
  input  wire logic        timer_three_ovf_i,
  input  wire logic        capcomp_capture_i,
  input  wire logic        capcomp_match_i,
  // flags and interrupt
  output logic      [5:0]  flags_o,
  output logic             irq_o
);

  pif_pkg::pif_state_t st_r;
  pif_pkg::pif_state_t st_nxt;

  logic [pif_pkg::FLAG_W-1:0] events;
  logic [pif_pkg::FLAG_W-1:0] flags;
  logic                       ccp_event;
  logic                       wr_done;
  logic                       wr_flags;

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  function automatic logic [31:0] zext6(input logic [5:0] v);
    zext6 = {26'h000_0000, v};
  endfunction : zext6

  // capture/compare flag source depends on the mode
  always_comb
  begin
    case (st_r.mode)
      pif_pkg::PIF_MODE_CAPTURE: ccp_event = capcomp_capture_i;
      pif_pkg::PIF_MODE_COMPARE: ccp_event = capcomp_match_i;
      pif_pkg::PIF_MODE_PWM:     ccp_event = 1'b0;
      default:                   ccp_event = 1'b0;
    endcase
  end

  always_comb
  begin
    events                     = '0;
    events[pif_pkg::BIT_USB]   = usb_req_i;
    events[pif_pkg::BIT_NVM]   = nvm_write_done_i;
    events[pif_pkg::BIT_BCOL]  = bus_collision_i;
    events[pif_pkg::BIT_VDET]  = voltage_trip_i;
    events[pif_pkg::BIT_TIMER_THREE]  = timer_three_ovf_i;
    events[pif_pkg::BIT_CCP2]  = ccp_event;
  end

  // a transfer completes at the edge where waitrequest is low
  assign wr_done  = avs_write_i && !st_r.waitreq;
  assign wr_flags = wr_done && avs_byteenable_i[0] && reg_hit(avs_address_i, pif_pkg::OFF_FLAGS);

  genvar g;
  generate
    for (g = 0; g < pif_pkg::FLAG_W; g++)
    begin : g_flag
      pif_flag_cell u_cell (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .set_i    (events[g]),
        .wr_en_i  (wr_flags),
        .wr_val_i (avs_writedata_i[g]),
        .flag_o   (flags[g])
      );
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    // bus handshake: one wait cycle, then completion
    if (st_r.waitreq && (avs_read_i || avs_write_i))
    begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = pif_pkg::RST_RDATA;
      if (avs_read_i)
      begin
        if (reg_hit(avs_address_i, pif_pkg::OFF_FLAGS))
        begin
          st_nxt.rdata = zext6(flags);
        end
        else if (reg_hit(avs_address_i, pif_pkg::OFF_STAT))
        begin
          st_nxt.rdata = zext6(st_r.stat);
        end
        else if (reg_hit(avs_address_i, pif_pkg::OFF_MASK))
        begin
          st_nxt.rdata = zext6(st_r.mask);
        end
        else if (reg_hit(avs_address_i, pif_pkg::OFF_MODE))
        begin
          st_nxt.rdata = {30'h0000_0000, st_r.mode};
        end
      end
    end
    else if (!st_r.waitreq)
    begin
      st_nxt.waitreq = 1'b1;
    end
    // register writes
    if (wr_done && avs_byteenable_i[0])
    begin
      if (reg_hit(avs_address_i, pif_pkg::OFF_STAT))
      begin
        st_nxt.stat = st_r.stat & ~avs_writedata_i[pif_pkg::FLAG_W-1:0];
      end
      if (reg_hit(avs_address_i, pif_pkg::OFF_MASK))
      begin
        st_nxt.mask = avs_writedata_i[pif_pkg::FLAG_W-1:0];
      end
      if (reg_hit(avs_address_i, pif_pkg::OFF_MODE))
      begin
        st_nxt.mode = pif_pkg::pif_ccp_mode_t'(
          avs_writedata_i[pif_pkg::MODE_LSB +: pif_pkg::MODE_W]);
      end
    end
    // sticky status, set after clear so an event is never lost
    st_nxt.stat = st_nxt.stat | events;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st_r.waitreq <= 1'b1;
      st_r.rdata   <= pif_pkg::RST_RDATA;
      st_r.stat    <= pif_pkg::RST_STAT;
      st_r.mask    <= pif_pkg::RST_MASK;
      st_r.mode    <= pif_pkg::RST_MODE;
      st_r.irq     <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o    = st_r.rdata;
  assign avs_waitrequest_o = st_r.waitreq;
  assign flags_o           = flags;
  assign irq_o             = st_r.irq;

endmodule : pif_flags
`default_nettype wire

// ==== bench/pif_flags_properties.sv ====
/* Port assertions of pif_flags.
   Assumes it is bound to pif_flags from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module pif_flags_properties (
  // clock and bus
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  // events and flags
  input wire logic       usb_req_i,
  input wire logic       nvm_write_done_i,
  input wire logic       bus_collision_i,
  input wire logic       voltage_trip_i,
  input wire logic       timer_three_ovf_i,
  input wire logic       capcomp_capture_i,
  input wire logic       capcomp_match_i,
  input wire logic [5:0] flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic wr_done = avs_write_i && !avs_waitrequest_o;
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_USB_SET: assert property (usb_req_i |=> flags_o[5])
    else $error("usb flag not set");
  AST_NVM_SET: assert property (nvm_write_done_i |=> flags_o[4])
    else $error("nvm flag not set");
  AST_BCOL_SET: assert property (bus_collision_i |=> flags_o[3])
    else $error("collision flag not set");
  AST_VDET_SET: assert property (voltage_trip_i |=> flags_o[2])
    else $error("voltage flag not set");
  AST_TIMER_THREE_SET: assert property (timer_three_ovf_i |=> flags_o[1])
    else $error("timer flag not set");
  AST_CCP_CAUSE: assert property ($rose(flags_o[0]) |->
    $past(capcomp_capture_i || capcomp_match_i || avs_write_i))
    else $error("capture flag set without cause");
  AST_HOLD: assert property (!wr_done |=> ($past(flags_o) & ~flags_o) == 6'h00)
    else $error("flag dropped without write");
  AST_SET_WINS: assert property (wr_done && timer_three_ovf_i |=> flags_o[1])
    else $error("clear beat event");
  AST_ANSWER: assert property ($rose(avs_read_i || avs_write_i) |-> ##1 s_answer)
    else $error("bus answer late");
endmodule : pif_flags_properties
`default_nettype wire

// ==== bench/pif_flags_tb_top.sv ====
/* Self-checking bench of pif_flags.
   Assumes the one-wait-cycle slave described for the block. */
`timescale 1ns/1ps
`default_nettype none
module pif_flags_tb_top;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [6:0]  ev = 7'h00;
  logic [31:0] q;
  logic [31:0] r;
  wire logic [31:0] rdata;
  wire logic        wreq;
  wire logic [5:0]  flags;
  wire logic        irq;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 20;
  always #10 clk_i = ~clk_i;
  pif_flags pif_flags_inst (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .usb_req_i(ev[5]),
    .nvm_write_done_i(ev[4]), .bus_collision_i(ev[3]), .voltage_trip_i(ev[2]),
    .timer_three_ovf_i(ev[1]), .capcomp_capture_i(ev[0]), .capcomp_match_i(ev[6]),
    .flags_o(flags), .irq_o(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic pulse(input logic [6:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 7'h00;
    repeat (3) @(negedge clk_i);
  endtask : pulse
  function automatic logic [5:0] expf(input logic [6:0] v, input logic [1:0] m);
    return {v[5:1], (v[0] && m == 2'd0) || (v[6] && m == 2'd1)};
  endfunction : expf
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    // every offset, unmapped ones included, reads zero out of reset
    for (int a = 0; a < 16; a++)
    begin
      bus(1'b0, a[3:0], 32'h0000_0000);
      chk(q, 32'h0000_0000);
    end
    $display("test 1 done");
    for (int k = 0; k < 6; k++)
    begin
      bus(1'b1, pif_pkg::OFF_FLAGS, 32'h0000_0000);
      pulse(7'(1 << k));
      chk({26'h0, flags}, 32'(1 << k));
    end
    $display("test 2 done");
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 2; s++)
      begin
        bus(1'b1, pif_pkg::OFF_MODE, 32'(m));
        bus(1'b1, pif_pkg::OFF_FLAGS, 32'h0000_0000);
        pulse(s ? 7'h40 : 7'h01);
        chk({26'h0, flags}, {26'h0, expf(s ? 7'h40 : 7'h01, m[1:0])});
      end
    $display("test 3 done");
    bus(1'b1, pif_pkg::OFF_MODE, 32'h0000_0000);
    bus(1'b1, pif_pkg::OFF_STAT, 32'h0000_003F);
    be <= 4'h0;
    bus(1'b1, pif_pkg::OFF_FLAGS, 32'h0000_003F);
    be <= 4'hF;
    bus(1'b1, pif_pkg::OFF_FLAGS, 32'h0000_0000);
    bus(1'b1, pif_pkg::OFF_MASK, 32'h0000_0020);
    bus(1'b0, pif_pkg::OFF_MASK, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    bus(1'b0, pif_pkg::OFF_MODE, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    pulse(7'h20);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b0, pif_pkg::OFF_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0020);
    bus(1'b1, pif_pkg::OFF_STAT, 32'h0000_0020);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({26'h0, flags}, 32'h0000_0020);
    $display("test 4 done");
    repeat (24)
    begin
      r = $random(seed);
      bus(1'b1, pif_pkg::OFF_FLAGS, r);
      @(negedge clk_i);
      chk({26'h0, flags}, {26'h0, r[5:0]});
      ev <= r[12:6];
      bus(1'b1, pif_pkg::OFF_FLAGS, 32'h0000_0000);
      ev <= 7'h00;
      @(negedge clk_i);
      chk({26'h0, flags}, {26'h0, expf(r[12:6], 2'd0)});
    end
    $display("test 5 done");
    conclude();
  end
endmodule : pif_flags_tb_top
bind pif_flags pif_flags_properties pif_flags_properties_inst (.clk_i(clk_i),
  .resetn_i(resetn_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .usb_req_i(usb_req_i),
  .nvm_write_done_i(nvm_write_done_i), .bus_collision_i(bus_collision_i),
  .voltage_trip_i(voltage_trip_i), .timer_three_ovf_i(timer_three_ovf_i),
  .capcomp_capture_i(capcomp_capture_i), .capcomp_match_i(capcomp_match_i),
  .flags_o(flags_o));
`default_nettype wire
